// >>> logic/pode_decoder.sv
// Privileged operation decoder and executor: status mask, cache invalidate,
// coprocessor state reload. Assumes the sequencer presents one opcode word
// per valid pulse, then the extension word, and holds the address file.
`timescale 1ns/1ps
`default_nettype none
module pode_decoder (
	// Clock and reset
	input  wire logic        CLOCK_IN,
	input  wire logic        ARST_N_IN,
	// Instruction word stream
	input  wire logic        WORD_VALID_IN,
	input  wire logic [15:0] WORD_IN,
	output logic             WORD_READY_OUT,
	// Address register read port
	output logic [2:0]       AREG_SEL_OUT,
	input  wire logic [31:0] AREG_DATA_IN,
	input  wire logic [31:0] EA_ADDR_IN,
	input  wire logic        PAGE_8K_IN,
	// Status word
	output logic [15:0]      SR_OUT,
	// Exception report
	output logic             EXC_VALID_OUT,
	output logic [2:0]       EXC_CODE_OUT,
	// Cache invalidate command
	output logic             INVAL_VALID_OUT,
	output logic             INVAL_DATA_OUT,
	output logic             INVAL_INSTR_OUT,
	output logic [1:0]       INVAL_SCOPE_OUT,
	output logic [31:0]      INVAL_ADDR_OUT,
	output logic [31:0]      INVAL_KEEP_MASK_OUT,
	output logic             INVAL_NO_WB_OUT,
	// Coprocessor reload
	output logic             CP_RELOAD_VALID_OUT,
	output logic [2:0]       CP_ID_OUT,
	output logic [31:0]      CP_ADDR_OUT,
	input  wire logic        CP_DONE_IN,
	input  wire logic        CP_COME_AGAIN_IN,
	output logic             IRQ_HOLD_OUT
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_inval(input logic [15:0] w);
		return (w[15:8] == pode_pkg::INVAL_HI_BYTE) && !w[5];
	endfunction

	function automatic logic is_reload(input logic [15:0] w);
		// Coprocessor id sits in 11:9, so only the top nibble and the type field in 8:6 are fixed
		return (w[15:12] == pode_pkg::RELOAD_HI_PREFIX[6:3])
			&& (w[8:6] == pode_pkg::RELOAD_TYPE);
	endfunction

	function automatic logic reload_mode_ok(input logic [5:0] ea);
		logic [2:0] m;
		m = ea[5:3];
		case (m)
			pode_pkg::MODE_IND, pode_pkg::MODE_POSTINC,
			pode_pkg::MODE_DISP, pode_pkg::MODE_INDEX: return 1'b1;
			pode_pkg::MODE_EXT: return ea[2:0] <= pode_pkg::EXT_REG_MAX;
			default: return 1'b0;
		endcase
	endfunction

	pode_pkg::pode_state_t state_q;
	logic [15:0]           sr_q;
	logic                  super_w;
	logic                  take_w;
	logic                  mask_op_w;
	logic                  inval_w;
	logic                  reload_w;
	logic [31:0]           keep_w;

	assign super_w   = sr_q[pode_pkg::SR_SUPER_BIT];
	assign take_w    = WORD_VALID_IN && WORD_READY_OUT;
	assign mask_op_w = take_w && state_q == pode_pkg::PODE_IDLE
		&& WORD_IN == pode_pkg::MASK_SR_OPCODE;
	assign inval_w   = take_w && state_q == pode_pkg::PODE_IDLE && is_inval(WORD_IN);
	assign reload_w  = take_w && state_q == pode_pkg::PODE_IDLE && is_reload(WORD_IN);
	assign WORD_READY_OUT = state_q != pode_pkg::PODE_RELOAD;
	assign AREG_SEL_OUT = WORD_IN[2:0];
	assign SR_OUT = sr_q;

	always_comb begin
		case (WORD_IN[4:3])
			pode_pkg::SCOPE_LINE: keep_w = pode_pkg::LINE_KEEP_MASK;
			pode_pkg::SCOPE_PAGE: keep_w = PAGE_8K_IN ? pode_pkg::PAGE8K_KEEP_MASK
				: pode_pkg::PAGE4K_KEEP_MASK;
			default: keep_w = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state_q <= pode_pkg::PODE_IDLE;
		end else begin
			case (state_q)
				pode_pkg::PODE_IDLE: begin
					if (mask_op_w && super_w)
						state_q <= pode_pkg::PODE_WAIT_EXT;
					else if (reload_w && super_w && WORD_IN[11:9] != 3'h0
						&& reload_mode_ok(WORD_IN[5:0]))
						state_q <= pode_pkg::PODE_RELOAD;
				end
				pode_pkg::PODE_WAIT_EXT: begin
					if (take_w)
						state_q <= pode_pkg::PODE_IDLE;
				end
				pode_pkg::PODE_RELOAD: begin
					if (CP_DONE_IN && !CP_COME_AGAIN_IN)
						state_q <= pode_pkg::PODE_IDLE;
				end
				default: state_q <= pode_pkg::PODE_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sr_q <= pode_pkg::SR_RESET;
		end else if (state_q == pode_pkg::PODE_WAIT_EXT && take_w) begin
			sr_q <= sr_q & WORD_IN;
		end
	end

	// ----------------------------------------
	// Exceptions
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			EXC_VALID_OUT <= 1'b0;
			EXC_CODE_OUT  <= 3'h0;
		end else begin
			EXC_VALID_OUT <= 1'b0;
			EXC_CODE_OUT  <= 3'h0;
			if (reload_w && WORD_IN[11:9] == 3'h0) begin
				EXC_VALID_OUT <= 1'b1;
				EXC_CODE_OUT  <= 3'(pode_pkg::PODE_EXC_FLINE);
			end else if (inval_w && WORD_IN[4:3] == pode_pkg::SCOPE_ILLEGAL) begin
				EXC_VALID_OUT <= 1'b1;
				EXC_CODE_OUT  <= 3'(pode_pkg::PODE_EXC_ILLEGAL);
			end else if ((mask_op_w || inval_w || reload_w) && !super_w) begin
				EXC_VALID_OUT <= 1'b1;
				EXC_CODE_OUT  <= 3'(pode_pkg::PODE_EXC_PRIV);
			end else if (reload_w && !reload_mode_ok(WORD_IN[5:0])) begin
				EXC_VALID_OUT <= 1'b1;
				EXC_CODE_OUT  <= 3'(pode_pkg::PODE_EXC_ILLEGAL);
			end
		end
	end

	// ----------------------------------------
	// Cache invalidate command
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			INVAL_VALID_OUT     <= 1'b0;
			INVAL_DATA_OUT      <= 1'b0;
			INVAL_INSTR_OUT     <= 1'b0;
			INVAL_SCOPE_OUT     <= 2'h0;
			INVAL_ADDR_OUT      <= 32'h0000_0000;
			INVAL_KEEP_MASK_OUT <= 32'h0000_0000;
			INVAL_NO_WB_OUT     <= 1'b0;
		end else begin
			INVAL_VALID_OUT <= 1'b0;
			INVAL_NO_WB_OUT <= 1'b0;
			if (inval_w && super_w && WORD_IN[4:3] != pode_pkg::SCOPE_ILLEGAL
				&& WORD_IN[7:6] != 2'h0) begin
				INVAL_VALID_OUT     <= 1'b1;
				INVAL_DATA_OUT      <= WORD_IN[6];
				INVAL_INSTR_OUT     <= WORD_IN[7];
				INVAL_SCOPE_OUT     <= WORD_IN[4:3];
				INVAL_ADDR_OUT      <= AREG_DATA_IN & keep_w;
				INVAL_KEEP_MASK_OUT <= keep_w;
				INVAL_NO_WB_OUT     <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Coprocessor reload
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			CP_RELOAD_VALID_OUT <= 1'b0;
			CP_ID_OUT           <= 3'h0;
			CP_ADDR_OUT         <= 32'h0000_0000;
		end else begin
			CP_RELOAD_VALID_OUT <= 1'b0;
			if (reload_w && super_w && WORD_IN[11:9] != 3'h0
				&& reload_mode_ok(WORD_IN[5:0])) begin
				CP_RELOAD_VALID_OUT <= 1'b1;
				CP_ID_OUT           <= WORD_IN[11:9];
				CP_ADDR_OUT         <= EA_ADDR_IN;
			end
		end
	end

	assign IRQ_HOLD_OUT = state_q == pode_pkg::PODE_RELOAD && CP_COME_AGAIN_IN;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence mask_pair_s;
		mask_op_w && super_w ##1 take_w;
	endsequence

	property mask_and_p;
		@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		mask_pair_s |=> SR_OUT == ($past(sr_q, 2) & $past(WORD_IN));
	endproperty

	status_and_a: assert property (mask_and_p)
		else $error("status AND wrong");

	user_mask_trap_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		mask_op_w && !super_w |=> EXC_VALID_OUT
			&& EXC_CODE_OUT == 3'(pode_pkg::PODE_EXC_PRIV) && $stable(SR_OUT))
		else $error("user mask not trapped");

	inval_priv_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_w && !super_w |=> !INVAL_VALID_OUT)
		else $error("user invalidate issued");

	line_low_bits_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		INVAL_VALID_OUT && INVAL_SCOPE_OUT == pode_pkg::SCOPE_LINE
			|-> INVAL_ADDR_OUT[3:0] == 4'h0)
		else $error("line bits not masked");

	page_low_bits_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		INVAL_VALID_OUT && INVAL_SCOPE_OUT == pode_pkg::SCOPE_PAGE
			|-> INVAL_ADDR_OUT[11:0] == 12'h000)
		else $error("page bits not masked");

	scope_illegal_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_w && super_w && WORD_IN[4:3] == 2'h0
			|=> EXC_CODE_OUT == 3'(pode_pkg::PODE_EXC_ILLEGAL) && !INVAL_VALID_OUT)
		else $error("illegal scope missed");

	cache_none_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_w && WORD_IN[7:6] == 2'h0 |=> !INVAL_VALID_OUT)
		else $error("no-cache issued");

	cp_zero_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		reload_w && WORD_IN[11:9] == 3'h0
			|=> EXC_CODE_OUT == 3'(pode_pkg::PODE_EXC_FLINE) && !CP_RELOAD_VALID_OUT)
		else $error("cp id zero reloaded");

	no_cc_change_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		(inval_w || reload_w) |=> $stable(SR_OUT[4:0]))
		else $error("cc changed");

	irq_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		state_q == pode_pkg::PODE_RELOAD && CP_COME_AGAIN_IN |-> IRQ_HOLD_OUT)
		else $error("irq not held");

	cc_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		mask_pair_s |=> (SR_OUT[4:0] & ~$past(WORD_IN[4:0])) == 5'h00)
		else $error("flag not cleared");

	// ----------------------------------------
	// Checks: invalidate and reload commands
	// ----------------------------------------
	sequence inval_go_s;
		inval_w && super_w && WORD_IN[4:3] != pode_pkg::SCOPE_ILLEGAL
			&& WORD_IN[7:6] != 2'h0;
	endsequence

	sequence reload_go_s;
		reload_w && super_w && WORD_IN[11:9] != 3'h0 && reload_mode_ok(WORD_IN[5:0]);
	endsequence

	inval_issue_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s |=> INVAL_VALID_OUT && INVAL_DATA_OUT == $past(WORD_IN[6])
			&& INVAL_INSTR_OUT == $past(WORD_IN[7]))
		else $error("invalidate command wrong");

	no_writeback_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s |=> INVAL_NO_WB_OUT)
		else $error("writeback not suppressed");

	line_addr_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s ##0 WORD_IN[4:3] == pode_pkg::SCOPE_LINE
			|=> INVAL_ADDR_OUT == ($past(AREG_DATA_IN) & pode_pkg::LINE_KEEP_MASK))
		else $error("line address wrong");

	page4k_addr_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s ##0 (WORD_IN[4:3] == pode_pkg::SCOPE_PAGE && !PAGE_8K_IN)
			|=> INVAL_ADDR_OUT == ($past(AREG_DATA_IN) & pode_pkg::PAGE4K_KEEP_MASK))
		else $error("4k page address wrong");

	page8k_addr_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s ##0 (WORD_IN[4:3] == pode_pkg::SCOPE_PAGE && PAGE_8K_IN)
			|=> INVAL_ADDR_OUT[12:0] == 13'h0000
			&& INVAL_ADDR_OUT[31:13] == $past(AREG_DATA_IN[31:13]))
		else $error("8k page address wrong");

	all_scope_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		inval_go_s ##0 WORD_IN[4:3] == pode_pkg::SCOPE_ALL
			|=> INVAL_SCOPE_OUT == pode_pkg::SCOPE_ALL
			&& INVAL_KEEP_MASK_OUT == 32'h0000_0000)
		else $error("all scope wrong");

	reload_start_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		reload_go_s |=> CP_RELOAD_VALID_OUT && CP_ID_OUT == $past(WORD_IN[11:9])
			&& CP_ADDR_OUT == $past(EA_ADDR_IN))
		else $error("reload not started");

	reload_priv_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		reload_w && !super_w |=> !CP_RELOAD_VALID_OUT && EXC_VALID_OUT)
		else $error("user reload not trapped");

	bad_mode_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		reload_w && !reload_mode_ok(WORD_IN[5:0]) |=> !CP_RELOAD_VALID_OUT)
		else $error("bad mode reloaded");

	come_again_wait_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
		state_q == pode_pkg::PODE_RELOAD && CP_COME_AGAIN_IN
			|=> state_q == pode_pkg::PODE_RELOAD)
		else $error("reload left on come-again");
endmodule
`default_nettype wire

// >>> logic/pode_pkg.sv
// Constants for the privileged operation decode and execute block.
// Assumes one clock domain and a sequencer that feeds one instruction at a time.
package pode_pkg;
	localparam logic [15:0] MASK_SR_OPCODE   = 16'h027c;
	localparam logic [7:0]  INVAL_HI_BYTE    = 8'hf4;
	localparam logic [6:0]  RELOAD_HI_PREFIX = 7'h78;
	localparam int          RELOAD_TYPE_LSB  = 6;
	localparam logic [2:0]  RELOAD_TYPE      = 3'h5;
	localparam logic [15:0] SR_RESET         = 16'h2700;
	localparam int          SR_SUPER_BIT     = 13;
	localparam logic [1:0]  SCOPE_ILLEGAL    = 2'h0;
	localparam logic [1:0]  SCOPE_LINE       = 2'h1;
	localparam logic [1:0]  SCOPE_PAGE       = 2'h2;
	localparam logic [1:0]  SCOPE_ALL        = 2'h3;
	localparam logic [31:0] LINE_KEEP_MASK   = 32'hffff_fff0;
	localparam logic [31:0] PAGE4K_KEEP_MASK = 32'hffff_f000;
	localparam logic [31:0] PAGE8K_KEEP_MASK = 32'hffff_e000;
	localparam logic [2:0]  MODE_IND         = 3'h2;
	localparam logic [2:0]  MODE_POSTINC     = 3'h3;
	localparam logic [2:0]  MODE_DISP        = 3'h5;
	localparam logic [2:0]  MODE_INDEX       = 3'h6;
	localparam logic [2:0]  MODE_EXT         = 3'h7;
	localparam logic [2:0]  EXT_REG_MAX      = 3'h4;
	typedef enum logic [2:0] {
		PODE_EXC_NONE,
		PODE_EXC_PRIV,
		PODE_EXC_ILLEGAL,
		PODE_EXC_FLINE
	} pode_exc_t;
	typedef enum {
		PODE_IDLE,
		PODE_WAIT_EXT,
		PODE_RELOAD
	} pode_state_t;
endpackage

// >>> testbench/pode_far_model.sv
// Far-side model: coprocessor answering a state reload.
// Assumes the decoder's one-cycle reload pulse and a single clock.
`timescale 1ns/1ps
`default_nettype none
module pode_far_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// Reload request and answer
	input  wire logic       reload_in,
	input  wire logic [3:0] lat_in,
	output logic            done_out,
	output logic            again_out
);
	logic [3:0] cnt_q;
	logic       busy_q;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			done_out <= 1'b0;
			again_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (reload_in) begin
				busy_q <= 1'b1;
				cnt_q <= lat_in;
				again_out <= (lat_in != 4'h0);
			end else if (busy_q) begin
				if (cnt_q == 4'h0) begin
					busy_q <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
				again_out <= (cnt_q > 4'h1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Testbench: opcode word sequences with expected outputs.
// Assumes the far-side model answers reloads; address file is a table here.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, arst_n, wv, wr, p8k, iv, id, ii, nowb, ev, cpv, done, again, hold;
	logic [15:0] word, stw, stw_exp;
	logic [2:0]  asel, ecode, cpid;
	logic [1:0]  isc;
	logic [31:0] adata, ea, iaddr, ikeep, cpaddr, a, kexp;
	logic [3:0]  lat;
	logic [31:0] areg [8];
	logic [5:0]  eas [9];
	logic        ok;
	int          bad_count, n_tests;
	assign adata = areg[asel];
	pode_decoder u_dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .WORD_VALID_IN(wv), .WORD_IN(word),
		.WORD_READY_OUT(wr), .AREG_SEL_OUT(asel), .AREG_DATA_IN(adata), .EA_ADDR_IN(ea),
		.PAGE_8K_IN(p8k), .SR_OUT(stw), .EXC_VALID_OUT(ev), .EXC_CODE_OUT(ecode),
		.INVAL_VALID_OUT(iv), .INVAL_DATA_OUT(id), .INVAL_INSTR_OUT(ii), .INVAL_SCOPE_OUT(isc),
		.INVAL_ADDR_OUT(iaddr), .INVAL_KEEP_MASK_OUT(ikeep), .INVAL_NO_WB_OUT(nowb),
		.CP_RELOAD_VALID_OUT(cpv), .CP_ID_OUT(cpid), .CP_ADDR_OUT(cpaddr), .CP_DONE_IN(done),
		.CP_COME_AGAIN_IN(again), .IRQ_HOLD_OUT(hold));
	pode_far_model u_far (.clk_in(clk), .arst_n_in(arst_n), .reload_in(cpv), .lat_in(lat),
		.done_out(done), .again_out(again));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task rst();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
	endtask
	task send(input logic [15:0] w);
		@(posedge clk);
		wv <= 1'b1;
		word <= w;
		@(posedge clk);
		wv <= 1'b0;
		#1;
	endtask
	task mask(input logic [15:0] ext);
		@(posedge clk);
		wv <= 1'b1;
		word <= 16'h027c;
		@(posedge clk);
		word <= ext;
		@(posedge clk);
		wv <= 1'b0;
		#1;
		stw_exp = stw_exp & ext;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
	initial begin
		{arst_n, wv, p8k, lat, word, ea} = '0;
		bad_count = 0;
		n_tests = 0;
		for (int i = 0; i < 8; i++) areg[i] = 32'h1234_5678 + 32'h1111_0000 * i;
		eas = '{6'o20, 6'o30, 6'o00, 6'o10, 6'o40, 6'o50, 6'o60, 6'o74, 6'o75};
		rst();
		stw_exp = 16'h2700;
		chk(stw, 16'h2700);
		mask(16'hfbfe);
		chk({ev, stw}, {1'b0, stw_exp});
		for (int c = 0; c < 4; c++) for (int s = 0; s < 4; s++) for (int pg = 0; pg < 2; pg++) begin
			@(posedge clk);
			p8k <= pg[0];
			send({8'hf4, 2'(c), 1'b0, 2'(s), 3'(c * 4 + s)});
			a = areg[3'(c * 4 + s)];
			kexp = s == 1 ? 32'hffff_fff0 : s == 3 ? 32'h0000_0000 :
				pg != 0 ? 32'hffff_e000 : 32'hffff_f000;
			chk({ev, ecode}, {s == 0, s == 0 ? 3'h2 : 3'h0});
			chk(stw, stw_exp);
			if (s != 0 && c != 0) begin
				chk({iv, nowb}, 2'b11);
				chk({id, ii, isc}, {c[0], c[1], 2'(s)});
				chk(ikeep, kexp);
				chk(iaddr, a & kexp);
			end else begin
				chk(iv, 1'b0);
			end
		end
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			ea <= 32'h0000_4000 + 32'h0000_0010 * i;
			lat <= (i % 2) != 0 ? 4'h0 : 4'h3;
			ok = eas[i][5:3] inside {3'h2, 3'h3, 3'h5, 3'h6}
				|| (eas[i][5:3] == 3'h7 && eas[i][2:0] <= 3'h4);
			send({7'h79, 3'h5, eas[i]});
			chk({cpv, ev, ecode}, {ok, !ok, ok ? 3'h0 : 3'h2});
			if (ok) begin
				chk({cpid, cpaddr}, {3'h1, ea});
				for (int k = 0; k < 40 && !wr; k++) begin
					chk(hold, again);
					@(posedge clk);
					#1;
				end
				chk(wr, 1'b1);
			end
			chk(stw, stw_exp);
		end
		send(16'hf150);
		chk({cpv, ev, ecode}, {1'b0, 1'b1, 3'h3});
		mask(16'hdfff);
		chk(stw, stw_exp);
		send(16'h027c);
		chk({ev, ecode, stw}, {1'b1, 3'h1, stw_exp});
		send(16'hf4d9);
		chk({iv, ev, ecode}, {1'b0, 1'b1, 3'h1});
		send(16'hf350);
		chk({cpv, ev, ecode}, {1'b0, 1'b1, 3'h1});
		rst();
		chk(stw, 16'h2700);
		give_verdict();
	end
endmodule
`default_nettype wire
